// [src/sma_pkg.sv]
// shared constants and types for the register access checker
`default_nettype none
package sma_pkg;

  typedef enum logic [2:0] {
    MODE_BOOT,
    MODE_TEST,
    MODE_FIRMWARE,
    MODE_SYSTEM,
    MODE_USER
  } sma_mode_t;

  typedef enum logic [2:0] {
    GRP_TEST,
    GRP_SEGCFG,
    GRP_CPU_GEN,
    GRP_CPU_DUP,
    GRP_SYSMGT,
    GRP_FWCFG,
    GRP_FWOS,
    GRP_HW
  } sma_grp_t;

  localparam int NHW = 16;
  localparam int NSEG = 16;
  localparam int SEG_AW = 4;
  localparam int HW_AW = 4;
  localparam int AW = 8;

  localparam logic [AW-1:0] OFF_FW_LOW = 8'h00;
  localparam logic [AW-1:0] OFF_FW_HIGH = 8'h04;
  localparam logic [AW-1:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [AW-1:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [AW-1:0] OFF_LAST_DENY = 8'h10;
  localparam logic [AW-1:0] OFF_DENY_CNT = 8'h14;
  localparam logic [AW-1:0] OFF_SEG_BASE = 8'h40;
  localparam logic [1:0] SEG_REGION = 2'h1;

  localparam int ST_DENY = 0;
  localparam int ST_COPY_DENY = 1;
  localparam int NST = 2;

  localparam logic [NHW-1:0] RST_FW_LOW = 16'h0000;
  localparam logic [NHW-1:0] RST_FW_HIGH = 16'h0000;
  localparam logic [NST-1:0] RST_IRQ_MASK = 2'h0;
  localparam logic [31:0] RST_SEG_ENTRY = 32'h0000_0000;

  localparam int SEG_RD_LSB = 0;
  localparam int SEG_WR_LSB = 16;

endpackage : sma_pkg
`default_nettype wire

// [src/sma_rights_mem.sv]
// segment table rights memory, registered read port
`timescale 1ns/10ps
`default_nettype none
module sma_rights_mem
  import sma_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [SEG_AW-1:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [SEG_AW-1:0] rd_addr,
  output logic [31:0] rd_data_r
);

  logic [31:0] entry_r [NSEG];

  ////////////////////////////////////////////////////////////////////////////
  // one flop row per segment entry
  for (genvar i = 0; i < NSEG; i++)
  begin : g_entry
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        entry_r[i] <= RST_SEG_ENTRY;
      else if (wr_en && (wr_addr == SEG_AW'(i)))
        entry_r[i] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rd_data_r <= RST_SEG_ENTRY;
    else
      rd_data_r <= entry_r[rd_addr];
  end

endmodule // sma_rights_mem
`default_nettype wire

// [src/sma_copy_priv.sv]
// copy engine privilege holder
`timescale 1ns/10ps
`default_nettype none
module sma_copy_priv
  import sma_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic copy_start,
  input wire logic copy_done,
  input wire sma_mode_t cpu_mode,
  output logic copy_busy_r,
  output sma_mode_t copy_mode_r
);

  ////////////////////////////////////////////////////////////////////////////
  // mode latched at start, held until done
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      copy_busy_r <= 1'b0;
      copy_mode_r <= MODE_BOOT;
    end
    else if (copy_busy_r && copy_done)
      copy_busy_r <= 1'b0;
    else if (!copy_busy_r && copy_start)
    begin
      copy_busy_r <= 1'b1;
      copy_mode_r <= cpu_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_copy_mode_hold: assert property (
    copy_busy_r && !copy_done |=> copy_busy_r && $stable(copy_mode_r))
    else $error("copy mode changed during copy");

  chk_copy_mode_latch: assert property (
    !copy_busy_r && copy_start |=> copy_busy_r && copy_mode_r == $past(cpu_mode))
    else $error("copy mode not latched at start");

endmodule // sma_copy_priv
`default_nettype wire

// [src/sma_access_ctrl.sv]
// special register access checker with apb configuration port
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module sma_access_ctrl
  import sma_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sma_mode_t cpu_mode,
  input wire logic sfr_req,
  input wire logic sfr_we,
  input wire sma_grp_t sfr_group,
  input wire logic [HW_AW-1:0] sfr_hw_idx,
  input wire logic [SEG_AW-1:0] sfr_seg,
  input wire logic sfr_from_copy,
  input wire logic copy_start,
  input wire logic copy_done,
  output logic sfr_done,
  output logic sfr_grant,
  output logic sfr_exc,
  output logic sfr_fwd_wr,
  output logic sfr_fwd_rd,
  output logic copy_busy,
  output logic irq
);

  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [NHW-1:0] fw_low_r;
  logic [NHW-1:0] fw_high_r;
  logic [NST-1:0] irq_stat_r;
  logic [NST-1:0] irq_stat_nxt;
  logic [NST-1:0] irq_mask_r;
  logic [15:0] deny_cnt_r;
  logic [11:0] last_deny_r;
  logic irq_r;
  logic s1_v_r;
  logic s1_we_r;
  logic s1_copy_r;
  sma_grp_t s1_grp_r;
  sma_mode_t s1_mode_r;
  logic [HW_AW-1:0] s1_idx_r;
  logic done_r;
  logic grant_r;
  logic exc_r;
  logic fwd_wr_r;
  logic fwd_rd_r;
  logic [31:0] seg_rdata;
  sma_mode_t copy_mode;
  sma_mode_t eff_mode;
  logic copy_busy_w;
  logic acc;
  logic wr_go;
  logic seg_hit;
  logic reg_hit;
  logic [31:0] rd_mux;
  logic allow;
  logic fw_ok;
  logic seg_ok;
  logic [NHW-1:0] seg_rd_bits;
  logic [NHW-1:0] seg_wr_bits;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state
  assign acc = psel && penable && !pready_r;
  assign wr_go = psel && penable && pready_r && pwrite && reg_hit && !pslverr_r;
  assign seg_hit = (paddr[AW-1:AW-2] == SEG_REGION) && (paddr[1:0] == 2'h0);

  always_comb
  begin
    reg_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFF_FW_LOW: rd_mux = {16'h0000, fw_low_r};
      OFF_FW_HIGH: rd_mux = {16'h0000, fw_high_r};
      OFF_IRQ_STAT: rd_mux = {30'h0, irq_stat_r};
      OFF_IRQ_MASK: rd_mux = {30'h0, irq_mask_r};
      OFF_LAST_DENY: rd_mux = {20'h0_0000, last_deny_r};
      OFF_DENY_CNT: rd_mux = {16'h0000, deny_cnt_r};
      default: reg_hit = seg_hit;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= acc;
      pslverr_r <= acc && !reg_hit;
      prdata_r <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // firewall and mask registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fw_low_r <= RST_FW_LOW;
      fw_high_r <= RST_FW_HIGH;
      irq_mask_r <= RST_IRQ_MASK;
    end
    else if (wr_go)
    begin
      if (paddr == OFF_FW_LOW)
        fw_low_r <= pwdata[NHW-1:0];
      if (paddr == OFF_FW_HIGH)
        fw_high_r <= pwdata[NHW-1:0];
      if (paddr == OFF_IRQ_MASK)
        irq_mask_r <= pwdata[NST-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // segment table and copy engine
  sma_rights_mem u_mem (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(wr_go && seg_hit),
    .wr_addr(paddr[SEG_AW+1:2]),
    .wr_data(pwdata),
    .rd_addr(sfr_seg),
    .rd_data_r(seg_rdata)
  );

  sma_copy_priv u_copy (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .copy_start(copy_start),
    .copy_done(copy_done),
    .cpu_mode(cpu_mode),
    .copy_busy_r(copy_busy_w),
    .copy_mode_r(copy_mode)
  );

  assign eff_mode = (sfr_from_copy && copy_busy_w) ? copy_mode : cpu_mode;

  ////////////////////////////////////////////////////////////////////////////
  // request stage
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_v_r <= 1'b0;
      s1_we_r <= 1'b0;
      s1_copy_r <= 1'b0;
      s1_grp_r <= GRP_TEST;
      s1_mode_r <= MODE_BOOT;
      s1_idx_r <= 4'h0;
    end
    else
    begin
      s1_v_r <= sfr_req;
      if (sfr_req)
      begin
        s1_we_r <= sfr_we;
        s1_copy_r <= sfr_from_copy && copy_busy_w;
        s1_grp_r <= sfr_group;
        s1_mode_r <= eff_mode;
        s1_idx_r <= sfr_hw_idx;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decision
  assign seg_rd_bits = seg_rdata[SEG_RD_LSB +: NHW];
  assign seg_wr_bits = seg_rdata[SEG_WR_LSB +: NHW];
  assign fw_ok = s1_we_r ? fw_high_r[s1_idx_r] : fw_low_r[s1_idx_r];
  assign seg_ok = s1_we_r ? seg_wr_bits[s1_idx_r] : seg_rd_bits[s1_idx_r];

  always_comb
  begin
    allow = 1'b0;
    case (s1_mode_r)
      MODE_BOOT:
        allow = !(s1_grp_r inside {GRP_TEST, GRP_SEGCFG, GRP_CPU_DUP});
      MODE_TEST:
        allow = !(s1_grp_r inside {GRP_SEGCFG, GRP_CPU_DUP});
      MODE_FIRMWARE:
        case (s1_grp_r)
          GRP_FWCFG: allow = !s1_we_r;
          GRP_FWOS: allow = 1'b1;
          GRP_HW: allow = fw_ok;
          GRP_CPU_GEN: allow = 1'b1;
          default: allow = 1'b0;
        endcase
      MODE_SYSTEM:
        allow = s1_grp_r inside {GRP_SEGCFG, GRP_SYSMGT, GRP_FWCFG, GRP_HW,
                                 GRP_CPU_GEN, GRP_CPU_DUP};
      MODE_USER:
        case (s1_grp_r)
          GRP_HW: allow = seg_ok;
          GRP_CPU_GEN: allow = 1'b1;
          GRP_CPU_DUP: allow = 1'b1;
          default: allow = 1'b0;
        endcase
      default: allow = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer stage
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_r <= 1'b0;
      grant_r <= 1'b0;
      exc_r <= 1'b0;
      fwd_wr_r <= 1'b0;
      fwd_rd_r <= 1'b0;
    end
    else
    begin
      done_r <= s1_v_r;
      grant_r <= s1_v_r && allow;
      exc_r <= s1_v_r && !allow;
      fwd_wr_r <= s1_v_r && allow && s1_we_r;
      fwd_rd_r <= s1_v_r && allow && !s1_we_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // denial log and interrupt
  always_comb
  begin
    irq_stat_nxt = irq_stat_r;
    if (wr_go && (paddr == OFF_IRQ_STAT))
      irq_stat_nxt = irq_stat_nxt & ~pwdata[NST-1:0];
    if (s1_v_r && !allow)
      irq_stat_nxt[ST_DENY] = 1'b1;
    if (s1_v_r && !allow && s1_copy_r)
      irq_stat_nxt[ST_COPY_DENY] = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_r <= 2'h0;
      irq_r <= 1'b0;
      deny_cnt_r <= 16'h0000;
      last_deny_r <= 12'h000;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_mask_r);
      if (s1_v_r && !allow)
      begin
        deny_cnt_r <= deny_cnt_r + 16'h0001;
        last_deny_r <= {s1_copy_r, s1_mode_r, s1_grp_r, s1_we_r, s1_idx_r};
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign sfr_done = done_r;
  assign sfr_grant = grant_r;
  assign sfr_exc = exc_r;
  assign sfr_fwd_wr = fwd_wr_r;
  assign sfr_fwd_rd = fwd_rd_r;
  assign copy_busy = copy_busy_w;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_req;
    sfr_req;
  endsequence

  sequence s_answer;
    ##2 done_r && (grant_r ^ exc_r);
  endsequence

  chk_req_answer: assert property (s_req |-> s_answer)
    else $error("request not answered two cycles later");

  chk_boot_denied: assert property (
    sfr_req && eff_mode == MODE_BOOT &&
    sfr_group inside {GRP_TEST, GRP_SEGCFG, GRP_CPU_DUP} |-> ##2 exc_r)
    else $error("boot mode access to blocked group");

  chk_test_granted: assert property (
    sfr_req && eff_mode == MODE_TEST && sfr_group == GRP_TEST |-> ##2 grant_r)
    else $error("test mode refused test group");

  chk_fw_cfg_ro: assert property (
    sfr_req && eff_mode == MODE_FIRMWARE && sfr_group == GRP_FWCFG
    |-> ##2 (grant_r == !$past(sfr_we, 2)))
    else $error("firmware firewall config access wrong");

  chk_fw_hw_rights: assert property (
    done_r && $past(s1_mode_r) == MODE_FIRMWARE && $past(s1_grp_r) == GRP_HW
    |-> grant_r == $past(fw_ok))
    else $error("firmware hardware access ignores firewall");

  chk_sys_groups: assert property (
    sfr_req && eff_mode == MODE_SYSTEM && sfr_group inside {GRP_SEGCFG, GRP_HW}
    |-> ##2 grant_r)
    else $error("system mode refused allowed group");

  chk_user_seg: assert property (
    done_r && $past(s1_mode_r) == MODE_USER && $past(s1_grp_r) == GRP_HW
    |-> grant_r == $past(seg_ok))
    else $error("user hardware access ignores segment entry");

  chk_cpu_gen: assert property (
    sfr_req && sfr_group == GRP_CPU_GEN &&
    eff_mode inside {MODE_BOOT, MODE_TEST, MODE_FIRMWARE, MODE_SYSTEM, MODE_USER}
    |-> ##2 grant_r)
    else $error("general cpu register refused");

  chk_deny_exc: assert property (
    done_r && !grant_r |-> exc_r && irq_stat_r[ST_DENY])
    else $error("refusal without exception");

  chk_segcfg_sys: assert property (
    sfr_req && sfr_group == GRP_SEGCFG && eff_mode != MODE_SYSTEM |-> ##2 !grant_r)
    else $error("segment config granted outside system mode");

  chk_no_fwd: assert property (
    exc_r |-> !fwd_wr_r && !fwd_rd_r)
    else $error("refused access forwarded");

endmodule // sma_access_ctrl
`default_nettype wire

// [testbench/sma_cpu_model.sv]
// processor core model issuing special register requests
`timescale 1ns/10ps
`default_nettype none
module sma_cpu_model
  import sma_pkg::*;
(
  input wire logic clk_sys,
  output var sma_mode_t cpu_mode,
  output var logic sfr_req,
  output var logic sfr_we,
  output var sma_grp_t sfr_group,
  output var logic [HW_AW-1:0] sfr_hw_idx,
  output var logic [SEG_AW-1:0] sfr_seg,
  output var logic sfr_from_copy,
  output var logic copy_start,
  output var logic copy_done
);
  initial
  begin
    cpu_mode = MODE_BOOT;
    {sfr_req, sfr_we, sfr_from_copy, copy_start, copy_done} = 5'h00;
    sfr_group = GRP_TEST;
    sfr_hw_idx = 4'h0;
    sfr_seg = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // one request, fields valid at the taking edge
  task automatic issue(input logic [2:0] m, input logic [2:0] g, input logic w,
                       input logic [3:0] i, input logic [3:0] s, input logic c);
    @(posedge clk_sys);
    cpu_mode <= sma_mode_t'(m);
    sfr_req <= 1'b1;
    sfr_we <= w;
    sfr_group <= sma_grp_t'(g);
    sfr_hw_idx <= i;
    sfr_seg <= s;
    sfr_from_copy <= c;
    copy_start <= 1'b0;
    copy_done <= 1'b0;
  endtask
  // no request; stale fields scrambled
  task automatic idle(input logic st, input logic dn);
    @(posedge clk_sys);
    sfr_req <= 1'b0;
    sfr_we <= ~sfr_we;
    sfr_hw_idx <= ~sfr_hw_idx;
    sfr_seg <= ~sfr_seg;
    copy_start <= st;
    copy_done <= dn;
  endtask
endmodule // sma_cpu_model
`default_nettype wire

// [testbench/test_sfr_mode_access_control.sv]
// self-checking bench for the register access checker
`timescale 1ns/10ps
`default_nettype none
module test_sfr_mode_access_control
  import sma_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, sfr_done, sfr_grant, sfr_exc, sfr_fwd_wr, sfr_fwd_rd, copy_busy, irq;
  sma_mode_t cpu_mode;
  sma_grp_t sfr_group;
  logic sfr_req, sfr_we, sfr_from_copy, copy_start, copy_done;
  logic [3:0] sfr_hw_idx, sfr_seg;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_deny = 0;
  int seed = 7775;
  logic [3:0] exp_q[$];
  logic [15:0] fwl, fwh;
  logic [31:0] seg [16];
  logic [31:0] rd, rv;
  logic er;

  always #50 clk_sys = ~clk_sys;

  sma_access_ctrl dut_u (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cpu_mode, .sfr_req, .sfr_we, .sfr_group, .sfr_hw_idx,
    .sfr_seg, .sfr_from_copy, .copy_start, .copy_done, .sfr_done, .sfr_grant, .sfr_exc,
    .sfr_fwd_wr, .sfr_fwd_rd, .copy_busy, .irq);
  sma_cpu_model cpu_u (.clk_sys, .cpu_mode, .sfr_req, .sfr_we, .sfr_group, .sfr_hw_idx,
    .sfr_seg, .sfr_from_copy, .copy_start, .copy_done);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected decision from mode, group, firewall and segment rights
  function automatic logic ok(input logic [2:0] m, input logic [2:0] g, input logic w,
                              input logic [3:0] i, input logic [3:0] s);
    case (m)
      MODE_BOOT: ok = !(g inside {GRP_TEST, GRP_SEGCFG, GRP_CPU_DUP});
      MODE_TEST: ok = !(g inside {GRP_SEGCFG, GRP_CPU_DUP});
      MODE_FIRMWARE: ok = g == GRP_CPU_GEN || g == GRP_FWOS || (g == GRP_FWCFG && !w)
        || (g == GRP_HW && (w ? fwh[i] : fwl[i]));
      MODE_SYSTEM: ok = g inside {GRP_SEGCFG, GRP_SYSMGT, GRP_FWCFG, GRP_HW, GRP_CPU_GEN,
        GRP_CPU_DUP};
      MODE_USER: ok = g inside {GRP_CPU_GEN, GRP_CPU_DUP}
        || (g == GRP_HW && seg[s][w ? 16 + i : i]);
      default: ok = 1'b0;
    endcase
  endfunction

  task automatic rq(input logic [2:0] ma, input logic [2:0] me, input logic [2:0] g,
                    input logic w, input logic [3:0] i, input logic [3:0] s, input logic c);
    logic a;
    a = ok(me, g, w, i, s);
    exp_q.push_back({a, !a, a & w, a & !w});
    if (!a)
      n_deny++;
    cpu_u.issue(ma, g, w, i, s, c);
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
    if (sfr_done === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(32'h1, 32'h0);
      else
        chk({28'h0, sfr_grant, sfr_exc, sfr_fwd_wr, sfr_fwd_rd}, {28'h0, exp_q.pop_front()});
    end

  initial
  begin
    #200000;
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, OFF_FW_LOW, 32'h0, rd, er);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    rv = $random(seed);
    fwl = rv[15:0];
    apb(1'b1, OFF_FW_LOW, {rv[31:16], fwl}, rd, er);
    rv = $random(seed);
    fwh = rv[15:0];
    apb(1'b1, OFF_FW_HIGH, rv, rd, er);
    apb(1'b0, OFF_FW_LOW, 32'h0, rd, er);
    chk(rd, {16'h0, fwl});
    apb(1'b0, OFF_FW_HIGH, 32'h0, rd, er);
    chk(rd, {16'h0, fwh});
    for (int k = 0; k < 16; k++)
    begin
      seg[k] = $random(seed);
      apb(1'b1, OFF_SEG_BASE + 8'(4 * k), seg[k], rd, er);
    end
    apb(1'b0, OFF_SEG_BASE, 32'h0, rd, er);
    chk(rd, 32'h0);
    for (int m = 0; m < 6; m++)
      for (int g = 0; g < 8; g++)
        for (int w = 0; w < 2; w++)
        begin
          rv = $random(seed);
          rq(3'(m), 3'(m), 3'(g), w[0], rv[3:0], rv[7:4], 1'b0);
        end
    // copy engine keeps the mode it started in
    rq(MODE_SYSTEM, MODE_SYSTEM, GRP_CPU_GEN, 1'b0, 4'h0, 4'h0, 1'b0);
    cpu_u.idle(1'b1, 1'b0);
    cpu_u.idle(1'b0, 1'b0);
    #1 chk({31'h0, copy_busy}, 32'h1);
    rq(MODE_USER, MODE_SYSTEM, GRP_SEGCFG, 1'b1, 4'h0, 4'h0, 1'b1);
    rq(MODE_USER, MODE_SYSTEM, GRP_TEST, 1'b0, 4'h0, 4'h0, 1'b1);
    cpu_u.idle(1'b0, 1'b1);
    cpu_u.idle(1'b0, 1'b0);
    rq(MODE_USER, MODE_USER, GRP_SEGCFG, 1'b1, 4'h0, 4'h0, 1'b1);
    repeat (4) cpu_u.idle(1'b0, 1'b0);
    apb(1'b0, OFF_DENY_CNT, 32'h0, rd, er);
    chk(rd, {16'h0, n_deny[15:0]});
    apb(1'b0, OFF_LAST_DENY, 32'h0, rd, er);
    chk(rd, 32'h0000_0430);
    apb(1'b0, OFF_IRQ_STAT, 32'h0, rd, er);
    chk(rd, 32'h3);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFF_IRQ_MASK, 32'h1, rd, er);
    repeat (2) cpu_u.idle(1'b0, 1'b0);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFF_IRQ_STAT, 32'h1, rd, er);
    repeat (2) cpu_u.idle(1'b0, 1'b0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, OFF_IRQ_STAT, 32'h0, rd, er);
    chk(rd, 32'h2);
    chk(32'(exp_q.size()), 32'h0);
    end_of_test();
  end
endmodule // test_sfr_mode_access_control
`default_nettype wire
